/* hw/gpx_pkg.sv */
package gpx_pkg;
  localparam int          PIN_COUNT      = 8;
  localparam int          LOW_PINS       = 4;
  localparam int          MODE_WIDTH     = 2;
  localparam int          EDGE_FLAG_BIT  = 7;
  localparam int          EDGE_EN_BIT    = 6;
  localparam int          EDGE_POL_BIT   = 5;
  localparam logic [7:0]  ADDR_MODE_LOW  = 8'h00;
  localparam logic [7:0]  ADDR_PIN_LEVEL = 8'h01;
  localparam logic [7:0]  ADDR_MODE_HIGH = 8'h07;
  localparam logic [7:0]  ADDR_EDGE      = 8'h08;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  CMD_REG_WRITE  = 8'h20;
  localparam logic [7:0]  CMD_REG_READ   = 8'h21;
  localparam logic [7:0]  CMD_REVISION   = 8'h40;
  localparam logic [1:0]  MODE_OPEN_DRAIN = 2'h0;
  localparam logic [1:0]  MODE_INPUT      = 2'h1;
  localparam logic [1:0]  MODE_PUSH_PULL  = 2'h2;
  localparam logic [1:0]  MODE_RESERVED   = 2'h3;
  localparam logic [2:0]  BIT_LAST       = 3'h7;
  localparam logic [2:0]  BIT_STEP       = 3'h1;

  typedef enum logic [1:0] {
    PIN_OPEN_DRAIN,
    PIN_INPUT,
    PIN_PUSH_PULL
  } gpx_pin_mode_type;

  typedef enum {
    ST_IDLE,
    ST_W_ADDR,
    ST_W_DATA,
    ST_R_ADDR,
    ST_REV_LO,
    ST_SINK
  } gpx_parse_state_type;

  typedef struct packed {
    logic flag;
    logic enable;
    logic polarity;
  } gpx_edge_ctrl_type;

  typedef struct packed {
    logic       cs_n;
    logic       rx_toggle;
    logic       edge_pin;
    logic [7:0] pins;
  } gpx_sync_type;

  localparam gpx_sync_type      SYNC_RESET = '{cs_n: 1'b1, rx_toggle: 1'b0, edge_pin: 1'b0, pins: 8'h00};
  localparam gpx_edge_ctrl_type EDGE_RESET = '{flag: 1'b0, enable: 1'b0, polarity: 1'b0};
endpackage

/* hw/gpx_gpio_expander.sv */
`timescale 1ns/1ps
// Operation
// RULE1: Low mode register holds two-bit fields for pins 3..0, pin 3 on top.
// RULE2: Mode 00 is open-drain output, 01 input only, 10 push-pull output.
// RULE3: Mode 11 is reserved for pins 0..3; software must not write it.
// RULE4: High mode register at 0x07 holds fields for pins 7..4, pin 7 on top.
// RULE5: For pins 4..7 mode 11 acts as input only.
// RULE6: Low mode register sits at 0x00; both mode registers reset to zero.
// RULE7: Level register at 0x01 drives output pins per bit; resets to zero.
// RULE8: Reading the level register returns the sampled pin levels.
// RULE9: Bit 7 of the edge register at 0x08 sets on the selected edge.
// RULE10: Bit 6 of the edge register enables the edge interrupt.
// RULE11: Bit 5 selects polarity: 0 rising edge, 1 falling edge.
// RULE12: Edge register bits 4..0 ignore writes and read as zero.
// RULE13: Edge register resets to zero: disabled, rising, flag clear.
// RULE14: Revision query is command 0x40 followed by one don't-care byte.
// RULE15: After the don't-care byte two BCD revision bytes follow, high first.
// RULE16: Reading the edge register clears the edge flag.
// RULE17: An enabled selected edge pulls the active-low interrupt output low.
// RULE18: The edge pin is synchronised before edge detection.
// RULE19: The interrupt output is released once the flag is cleared by a read.
module gpx_gpio_expander
  import gpx_pkg::*;
#(
  // Revision bytes in BCD; the values are arbitrary.
  parameter logic [7:0] REV_HI = 8'h01,
  parameter logic [7:0] REV_LO = 8'h00
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       spi_sclk_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic       spi_mosi_in,
  output logic            spi_miso_out,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe_n_out,
  input  wire logic       edge_source_pin_in,
  output logic            irq_n_out
);

  function automatic gpx_pin_mode_type decode_mode(input logic [1:0] code);
    gpx_pin_mode_type mode;
    mode = PIN_INPUT;
    if (code == MODE_OPEN_DRAIN) begin
      mode = PIN_OPEN_DRAIN;
    end else if (code == MODE_PUSH_PULL) begin
      mode = PIN_PUSH_PULL;
    end
    return mode;
  endfunction

  // Link side, clocked by the serial clock. Chip select high resets the bit counter, shift register and reply hold, not the received byte or its toggle.
  logic       link_rst_n;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_shift_q;
  logic [7:0] rx_byte_q;
  logic       rx_toggle_q;
  logic [7:0] tx_hold_q;
  logic [7:0] tx_q;
  wire        byte_end = (bit_cnt_q == BIT_LAST);

  assign link_rst_n = resetn_in & ~spi_cs_n_in;

  // The reply byte is fixed early in the byte before it is loaded here, so it is quiet at this edge.
  always_ff @(posedge spi_sclk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_q  <= 3'h0;
      rx_shift_q <= 7'h00;
      tx_hold_q  <= REG_RESET;
    end else begin
      bit_cnt_q  <= bit_cnt_q + BIT_STEP;
      rx_shift_q <= {rx_shift_q[5:0], spi_mosi_in};
      if (byte_end) begin
        tx_hold_q <= tx_q;
      end
    end
  end

  // The toggle survives the frame so that a new frame never fakes a byte.
  always_ff @(posedge spi_sclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_byte_q   <= REG_RESET;
      rx_toggle_q <= 1'b0;
    end else if (byte_end && !spi_cs_n_in) begin
      rx_byte_q   <= {rx_shift_q, spi_mosi_in};
      rx_toggle_q <= ~rx_toggle_q;
    end
  end

  assign spi_miso_out = tx_hold_q[~bit_cnt_q];

  // Core side: three-stage synchroniser, a change is taken once stages two and three agree.
  gpx_sync_type sync1_q;
  gpx_sync_type sync2_q;
  gpx_sync_type sync3_q;
  gpx_sync_type stable_q;
  gpx_sync_type prev_q;
  gpx_sync_type sync_raw;
  wire [10:0]   sync_agree = ~(sync2_q ^ sync3_q);
  wire [10:0]   stable_d   = (sync3_q & sync_agree) | (stable_q & ~sync_agree);

  assign sync_raw = '{cs_n: spi_cs_n_in, rx_toggle: rx_toggle_q, edge_pin: edge_source_pin_in, pins: pin_in};

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_q  <= SYNC_RESET;
      sync2_q  <= SYNC_RESET;
      sync3_q  <= SYNC_RESET;
      stable_q <= SYNC_RESET;
      prev_q   <= SYNC_RESET;
    end else begin
      sync1_q  <= sync_raw;
      sync2_q  <= sync1_q;
      sync3_q  <= sync2_q;
      stable_q <= stable_d; // [RULE18]
      prev_q   <= stable_q;
    end
  end

  wire byte_evt  = (stable_q.rx_toggle != prev_q.rx_toggle) && !stable_q.cs_n;
  wire edge_rise = stable_q.edge_pin & ~prev_q.edge_pin;
  wire edge_fall = ~stable_q.edge_pin & prev_q.edge_pin;

  // Registers and command parser.
  logic [7:0]          mode_low_q;
  logic [7:0]          pin_level_q;
  logic [7:0]          mode_high_q;
  gpx_edge_ctrl_type   edge_q;
  gpx_edge_ctrl_type   edge_d;
  gpx_parse_state_type state_q;
  gpx_parse_state_type state_d;
  logic [7:0]          addr_q;
  logic [7:0]          tx_d;
  logic                irq_n_q;

  wire       write_strobe    = byte_evt && (state_q == ST_W_DATA);
  wire       read_strobe     = byte_evt && (state_q == ST_R_ADDR);
  wire       wr_mode_low     = write_strobe && (addr_q == ADDR_MODE_LOW);
  wire       wr_level        = write_strobe && (addr_q == ADDR_PIN_LEVEL);
  wire       wr_mode_high    = write_strobe && (addr_q == ADDR_MODE_HIGH);
  wire       wr_edge         = write_strobe && (addr_q == ADDR_EDGE);
  wire       edge_read_clear = read_strobe && (rx_byte_q == ADDR_EDGE); // [RULE16]
  wire       edge_hit        = edge_q.polarity ? edge_fall : edge_rise; // [RULE11]
  wire       edge_set        = edge_q.enable && edge_hit; // [RULE10]
  wire [7:0] edge_read       = {edge_q.flag, edge_q.enable, edge_q.polarity, 5'h00}; // [RULE12]
  wire [7:0] read_value      = (rx_byte_q == ADDR_MODE_LOW)  ? mode_low_q :
                               (rx_byte_q == ADDR_PIN_LEVEL) ? stable_q.pins : // [RULE8]
                               (rx_byte_q == ADDR_MODE_HIGH) ? mode_high_q :
                               (rx_byte_q == ADDR_EDGE)      ? edge_read : REG_RESET;

  // A new edge in the cycle of a clearing read keeps the flag set.
  always_comb begin
    edge_d      = edge_q;
    edge_d.flag = edge_set | (edge_q.flag & ~edge_read_clear); // [RULE9] [RULE16]
    if (wr_edge) begin
      edge_d.enable   = rx_byte_q[EDGE_EN_BIT];
      edge_d.polarity = rx_byte_q[EDGE_POL_BIT];
    end
  end

  // A reply is set on the byte before the don't-care byte, and goes out after it.
  always_comb begin
    state_d = state_q;
    tx_d    = tx_q;
    if (stable_q.cs_n) begin
      state_d = ST_IDLE;
      tx_d    = REG_RESET;
    end else if (byte_evt) begin
      case (state_q)
        ST_IDLE: begin
          if (rx_byte_q == CMD_REG_WRITE) begin
            state_d = ST_W_ADDR;
          end else if (rx_byte_q == CMD_REG_READ) begin
            state_d = ST_R_ADDR;
          end else if (rx_byte_q == CMD_REVISION) begin
            state_d = ST_REV_LO;
            tx_d    = REV_HI; // [RULE14] [RULE15]
          end else begin
            state_d = ST_SINK;
          end
        end
        ST_W_ADDR: begin
          state_d = ST_W_DATA;
        end
        ST_R_ADDR: begin
          state_d = ST_SINK;
          tx_d    = read_value;
        end
        ST_REV_LO: begin
          state_d = ST_SINK;
          tx_d    = REV_LO; // [RULE15]
        end
        ST_W_DATA: begin
          state_d = ST_SINK;
        end
        default: begin
          state_d = ST_SINK;
          tx_d    = REG_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
      addr_q  <= REG_RESET;
      tx_q    <= REG_RESET;
      edge_q  <= EDGE_RESET; // [RULE13]
      irq_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      tx_q    <= tx_d;
      edge_q  <= edge_d;
      irq_n_q <= ~edge_d.flag; // [RULE17] [RULE19]
      if (byte_evt && (state_q == ST_W_ADDR || state_q == ST_R_ADDR)) begin
        addr_q <= rx_byte_q;
      end
    end
  end

  // Mode and level registers.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_low_q  <= REG_RESET; // [RULE6]
      pin_level_q <= REG_RESET;
      mode_high_q <= REG_RESET;
    end else begin
      if (wr_mode_low) begin
        mode_low_q <= rx_byte_q; // [RULE1]
      end
      if (wr_level) begin
        pin_level_q <= rx_byte_q; // [RULE7]
      end
      if (wr_mode_high) begin
        mode_high_q <= rx_byte_q; // [RULE4]
      end
    end
  end

  assign irq_n_out = irq_n_q;

  // Pin drivers. Reserved code 11 on the low pins releases the pin as a safe default.
  logic [7:0] pin_out_d;
  logic [7:0] pin_oe_n_d;
  logic [7:0] pin_out_q;
  logic [7:0] pin_oe_n_q;

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    wire [1:0] code = (i < LOW_PINS) ? mode_low_q[(i % LOW_PINS) * MODE_WIDTH +: MODE_WIDTH] :
                                       mode_high_q[(i % LOW_PINS) * MODE_WIDTH +: MODE_WIDTH]; // [RULE1] [RULE4]
    wire gpx_pin_mode_type mode = decode_mode(code); // [RULE2] [RULE3] [RULE5]
    assign pin_out_d[i]  = (mode == PIN_PUSH_PULL) && pin_level_q[i]; // [RULE7]
    assign pin_oe_n_d[i] = (mode == PIN_INPUT) || ((mode == PIN_OPEN_DRAIN) && pin_level_q[i]);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_out_q  <= 8'h00;
      pin_oe_n_q <= 8'h00;
    end else begin
      pin_out_q  <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  assign pin_out      = pin_out_q;
  assign pin_oe_n_out = pin_oe_n_q;

  // Checks.
  flag_set_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE9]
    edge_set |=> edge_q.flag) else $error("edge flag not set after a selected edge");
  flag_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE10]
    (!edge_q.enable && !edge_q.flag) |=> !edge_q.flag) else $error("edge flag set while disabled");
  polarity_sel_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE11]
    (edge_q.enable && !edge_q.flag && edge_q.polarity && edge_rise) |=> !edge_q.flag)
    else $error("rising edge set the flag under falling polarity");
  read_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE16]
    (edge_read_clear && !edge_set) |=> (!edge_q.flag && tx_q[EDGE_FLAG_BIT] == $past(edge_q.flag)))
    else $error("edge register read did not clear the flag");
  irq_follow_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE17]
    edge_set |=> !irq_n_out ##1 (!irq_n_out || $past(edge_read_clear)))
    else $error("interrupt output not low after edge");
  irq_release_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE19]
    $fell(edge_q.flag) |-> irq_n_out) else $error("interrupt output held after flag clear");
  level_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE7]
    (wr_level && mode_low_q[1:0] == MODE_PUSH_PULL && !wr_mode_low) |=> ##1
    (!pin_oe_n_out[0] && pin_out[0] == $past(rx_byte_q[0], 2))) else $error("push-pull pin 0 not driven");
  high_input_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE5]
    (mode_high_q[7:6] == MODE_RESERVED) |=> pin_oe_n_out[7]) else $error("pin 7 driven in code 11");
  od_release_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE2]
    (mode_low_q[1:0] == MODE_OPEN_DRAIN && pin_level_q[0]) |=> (pin_oe_n_out[0] && !pin_out[0]))
    else $error("open-drain pin 0 not released for a high level");
  od_drive_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE2]
    (mode_low_q[1:0] == MODE_OPEN_DRAIN && !pin_level_q[0]) |=> (!pin_oe_n_out[0] && !pin_out[0]))
    else $error("open-drain pin 0 not driven low");
  input_only_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE2]
    (mode_low_q[3:2] == MODE_INPUT) |=> (pin_oe_n_out[1] && !pin_out[1]))
    else $error("input-only pin 1 driven");
  readback_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE8]
    (read_strobe && rx_byte_q == ADDR_PIN_LEVEL) |=> tx_q == $past(stable_q.pins))
    else $error("level read does not return pin levels");
  reserved_zero_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE12]
    (read_strobe && rx_byte_q == ADDR_EDGE) |=> tx_q[4:0] == 5'h00) else $error("edge reserved bits not zero");
  revision_seq_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE15]
    (byte_evt && state_q == ST_IDLE && rx_byte_q == CMD_REVISION) |=> (tx_q == REV_HI && state_q == ST_REV_LO))
    else $error("revision high byte not prepared");
endmodule

/* bench/gpx_host_model.sv */
`timescale 1ns/1ps
module gpx_host_model (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // One four-byte frame, mode 0, MSB first; the clock stands low between frames.
  // Reply bits are taken at the end of the low phase, where they have stood longest.
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    int i;
    #13 cs_n_out = 1'b0;
    #300;
    for (i = 31; i >= 0; i--) begin
      mosi_out = tx[i];
      #40 rx[i] = miso_in;
      sclk_out = 1'b1;
      #40 sclk_out = 1'b0;
    end
    #40 cs_n_out = 1'b1;
    // A released data line must not keep showing the last bit.
    mosi_out = ~mosi_out;
    #500;
  endtask
endmodule

/* bench/gpx_gpio_expander_tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module gpx_gpio_expander_tb_top;
  import gpx_pkg::*;
  localparam logic [7:0] RV_HI = 8'h12;
  localparam logic [7:0] RV_LO = 8'h34;
  logic        clk_in, resetn_in, sclk, cs_n, mosi, miso, edge_pin, irq_n;
  logic [7:0]  pin_in, pin_out, pin_oe_n, ext_val, ext_en, e_oe, e_out, d;
  logic [7:0]  m_lo, m_hi, lvl;
  logic [31:0] rx;
  logic [7:0]  addrs [5];
  int          err_total, samples_checked, i, k;

  gpx_gpio_expander #(.REV_HI(RV_HI), .REV_LO(RV_LO)) dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n_out(pin_oe_n), .edge_source_pin_in(edge_pin), .irq_n_out(irq_n));
  gpx_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));

  // Undriven pins float high through their pull-ups.
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ~ext_en) | (pin_oe_n & ext_en & ext_val);

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] r;
    @(negedge clk_in);
    host.frame({CMD_REG_WRITE, a, v, 8'($urandom)}, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] r;
    @(negedge clk_in);
    host.frame({CMD_REG_READ, a, 16'($urandom)}, r);
    v = r[7:0];
  endtask

  task automatic model_pins();
    logic [1:0] m;
    for (int p = 0; p < 8; p++) begin
      m = (p < 4) ? m_lo[2*p +: 2] : m_hi[2*(p-4) +: 2];
      e_oe[p] = !((m == MODE_PUSH_PULL) || (m == MODE_OPEN_DRAIN && !lvl[p]));
      e_out[p] = (m == MODE_PUSH_PULL) && lvl[p];
    end
  endtask

  task automatic edge_step(input logic [7:0] c, input logic v);
    logic f;
    f = c[6] && (v != edge_pin) && (v == !c[5]);
    wr(ADDR_EDGE, c);
    @(negedge clk_in) edge_pin = v;
    repeat (10) @(negedge clk_in);
    `CHK(irq_n, !f)
    rd(ADDR_EDGE, d);
    `CHK(d, {f, c[6:5], 5'h00})
    repeat (10) @(negedge clk_in);
    `CHK(irq_n, 1'b1)
  endtask

  initial begin
    void'($urandom(32'he648));
    resetn_in = 1'b0;
    edge_pin = 1'b0;
    ext_val = 8'h00;
    ext_en = 8'h00;
    m_lo = 8'h00;
    m_hi = 8'h00;
    lvl = 8'h00;
    addrs = '{ADDR_MODE_LOW, ADDR_PIN_LEVEL, ADDR_MODE_HIGH, ADDR_EDGE, 8'h05};
    repeat (4) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (6) @(negedge clk_in);
    model_pins();
    `CHK(pin_oe_n, e_oe)
    `CHK(pin_out, e_out)
    wr(8'h05, 8'h5a);
    for (i = 0; i < 5; i++) begin
      rd(addrs[i], d);
      `CHK(d, 8'h00)
    end
    for (k = 0; k < 8; k++) begin
      @(negedge clk_in) ext_en = 8'h00;
      for (i = 0; i < 4; i++)
        m_lo[2*i +: 2] = 2'($urandom_range(2, 0));
      m_hi = 8'($urandom);
      lvl = 8'($urandom);
      wr(ADDR_MODE_LOW, m_lo);
      wr(ADDR_MODE_HIGH, m_hi);
      wr(ADDR_PIN_LEVEL, lvl);
      model_pins();
      @(negedge clk_in);
      ext_val = 8'($urandom);
      ext_en = 8'($urandom) & e_oe;
      repeat (10) @(negedge clk_in);
      `CHK(pin_oe_n, e_oe)
      `CHK(pin_out, e_out)
      rd(ADDR_PIN_LEVEL, d);
      `CHK(d, (~e_oe & e_out) | (e_oe & ~ext_en) | (e_oe & ext_en & ext_val))
      rd(ADDR_MODE_LOW, d);
      `CHK(d, m_lo)
      rd(ADDR_MODE_HIGH, d);
      `CHK(d, m_hi)
    end
    edge_step(8'h5f, 1'b1);
    edge_step(8'hdf, 1'b0);
    edge_step(8'h7f, 1'b1);
    edge_step(8'h7f, 1'b0);
    edge_step(8'h1f, 1'b1);
    edge_step(8'h1f, 1'b0);
    @(negedge clk_in);
    host.frame({CMD_REVISION, 24'($urandom)}, rx);
    `CHK(rx[15:8], RV_HI)
    `CHK(rx[7:0], RV_LO)
    final_report();
  end

  initial begin
    #1000000;
    err_total++;
    final_report();
  end
endmodule
